// ---- core/smb_slave_cmd.sv ----
// Command decoder and status for the two-wire management slave
`timescale 1ns/1ns
`default_nettype none
`include "smb_regs.svh"
module smb_slave_cmd
    import smb_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       link_clk,
    input  wire logic       link_rst,
    input  wire logic       resume_well_reset_n,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    input  wire logic [6:0] receive_slave_address,
    input  wire logic [2:0] power_state,
    input  wire logic       mgmt_power_on,
    input  wire logic       graceful_sleep,
    input  wire logic       wake_status_clr,
    input  wire logic       link_slave_status_clr,
    output logic            wake_request,
    output logic            system_mgmt_interrupt,
    output logic            wake_event_status,
    output logic            power_button_override_status,
    output logic            reset_port_strobe,
    output logic [3:0]      reset_port_value,
    output logic            messaging_enable,
    output logic            watchdog_reload,
    output logic            link_slave_mgmt_irq_status,
    output logic            link_slave_mgmt_irq
);
    logic       link_oe;
    logic       tgl;
    logic [7:0] creg, cdat;
    logic [2:0] tgl_s_q;
    logic [7:0] reg_q, dat_q;
    logic [1:0] rw_s_q;
    logic [2:0] ps_s_q, ps_q;
    logic [7:0] state_byte_q;
    logic       awake, sleep3;
    logic       cmd_ev, cmd_ev_q;

    // Read-back byte built on link side from the synced power state
    always_ff @(posedge link_clk) begin
        ps_s_q <= power_state;
        ps_q   <= ps_s_q;
    end

    // Register 0 reads zero, register 1 the power state, else zero
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            state_byte_q <= 8'h00;
        end else begin
            state_byte_q <= `SMB_CAPABILITY_VAL;
            if (creg == `SMB_REG_POWER_STATE) begin
                state_byte_q <= {5'h00, ps_q};
            end
        end
    end

    smb_link u_link (
        .link_clk   (link_clk),
        .link_rst   (link_rst),
        .scl_i      (scl_i),
        .sda_i      (sda_i),
        .sda_oe     (link_oe),
        .slave_addr (receive_slave_address),
        .state_byte (state_byte_q),
        .cmd_tgl    (tgl),
        .cmd_reg    (creg),
        .cmd_data   (cdat)
    );
    // Open-drain: only ever drives low
    always_ff @(posedge link_clk) begin
        sda_oe <= link_oe;
        sda_o  <= 1'b0;
    end

    // Toggle crossing; words taken only after the toggle clears both
    // sync stages, so they have long been stable on the link side
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tgl_s_q  <= 3'h0;
            reg_q    <= 8'h00;
            dat_q    <= 8'h00;
            cmd_ev_q <= 1'b0;
        end else begin
            tgl_s_q  <= {tgl_s_q[1:0], tgl};
            cmd_ev_q <= tgl_s_q[2] ^ tgl_s_q[1];
            if (tgl_s_q[2] ^ tgl_s_q[1]) begin
                reg_q <= creg;
                dat_q <= cdat;
            end
        end
    end
    assign cmd_ev = cmd_ev_q && reg_q == `SMB_WR_REG_COMMAND;
    assign awake  = power_state == `SMB_PS_S0;
    assign sleep3 = power_state == `SMB_PS_S3 || power_state == `SMB_PS_S4
                    || power_state == `SMB_PS_S5;

    // One-cycle action pulses; unknown codes fall through silently
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wake_request          <= 1'b0;
            system_mgmt_interrupt <= 1'b0;
            reset_port_strobe     <= 1'b0;
            reset_port_value      <= 4'h0;
            watchdog_reload       <= 1'b0;
        end else begin
            wake_request          <= 1'b0;
            system_mgmt_interrupt <= 1'b0;
            reset_port_strobe     <= 1'b0;
            watchdog_reload       <= 1'b0;
            if (cmd_ev) begin
                case (dat_q)
                    `SMB_CMD_WAKE: begin
                        wake_request          <= !awake;
                        system_mgmt_interrupt <= awake;
                    end
                    `SMB_CMD_RESET_WARM: begin
                        if (awake) begin
                            reset_port_strobe <= 1'b1;
                            reset_port_value  <= `SMB_RSTPORT_WARM;
                        end
                    end
                    `SMB_CMD_RESET_COLD: begin
                        if (awake || mgmt_power_on || graceful_sleep) begin
                            reset_port_strobe <= 1'b1;
                            reset_port_value  <= `SMB_RSTPORT_COLD;
                        end
                    end
                    `SMB_CMD_WATCHDOG_RELOAD_COMMAND: watchdog_reload <= 1'b1;
                    default: ;
                endcase
            end
        end
    end

    // Sticky status bits; a set wins over a same-cycle clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wake_event_status            <= 1'b0;
            power_button_override_status <= 1'b0;
            link_slave_mgmt_irq_status   <= 1'b0;
        end else begin
            if (cmd_ev && dat_q == `SMB_CMD_WAKE) begin
                wake_event_status <= 1'b1;
            end else if (wake_status_clr) begin
                wake_event_status <= 1'b0;
            end
            if (cmd_ev && dat_q == `SMB_CMD_POWERDOWN) begin
                power_button_override_status <= 1'b1;
            end
            if (cmd_ev && dat_q == `SMB_CMD_LINK_SMI && awake) begin
                link_slave_mgmt_irq_status <= 1'b1;
            end else if (link_slave_status_clr) begin
                link_slave_mgmt_irq_status <= 1'b0;
            end
        end
    end

    // Interrupt held off while asleep, raised again back in S0
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            link_slave_mgmt_irq <= 1'b0;
        end else begin
            link_slave_mgmt_irq <= link_slave_mgmt_irq_status && awake
                                   && !sleep3;
        end
    end

    // A resume-well reset or sys_rst brings messaging back
    always_ff @(posedge clk) begin
        rw_s_q <= {rw_s_q[0], resume_well_reset_n};
        if (sys_rst || !rw_s_q[1]) begin
            messaging_enable <= 1'b1;
        end else if (cmd_ev && dat_q == `SMB_CMD_MSG_DISABLE) begin
            messaging_enable <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- common/smb_regs.svh ----
// Constants for the two-wire management slave command decoder
// Summary of operation
// - Command 1 wakes a sleeping system, else raises a management interrupt.
// - Command 1 always sets wake status; it holds until software clears it.
// - Command 2 sets power-button-override status, same as a real override.
// - Command 3 requests hard reset without power cycle (reset port bits 2:1).
// - Command 3 is dropped unless the system is fully on.
// - Command 4 requests hard reset with power cycle (reset port bits 3:1).
// - Command 4 accepted with management power, or after graceful sleep entry.
// - Command 5 stops health messages until resume-well reset pulses.
// - Command 6 reloads the watchdog with its starting value.
// - Command 8 sets link-slave status in S0; in S3-S5 acked, not set.
// - Link-slave status pending at sleep raises its interrupt on return to S0.
// - Master sends 8-bit register select; device acknowledges it.
// - Device drives one data byte; master answers not-ack then stop.
// - Read register 0 always returns zero.
// - Read register 1 bits 2:0 give power state: 000,011,100,101.
// - Receive slave address defaults to 44h; wire bytes 88h and 89h.
`ifndef SMB_REGS_SVH
`define SMB_REGS_SVH
`define SMB_REG_CAPABILITY   8'h00
`define SMB_REG_POWER_STATE  8'h01
`define SMB_CAPABILITY_VAL   8'h00
`define SMB_SLAVE_ADDR_RST   7'h44
`define SMB_WR_REG_COMMAND   8'h00
`define SMB_CMD_WAKE         8'h01
`define SMB_CMD_POWERDOWN    8'h02
`define SMB_CMD_RESET_WARM   8'h03
`define SMB_CMD_RESET_COLD   8'h04
`define SMB_CMD_MSG_DISABLE  8'h05
`define SMB_CMD_WATCHDOG_RELOAD_COMMAND    8'h06
`define SMB_CMD_LINK_SMI     8'h08
`define SMB_PS_S0            3'h0
`define SMB_PS_S3            3'h3
`define SMB_PS_S4            3'h4
`define SMB_PS_S5            3'h5
`define SMB_RSTPORT_WARM     4'h6
`define SMB_RSTPORT_COLD     4'hE
`endif

// ---- common/smb_pkg.sv ----
// Types for the two-wire management slave command decoder
package smb_pkg;
    typedef enum logic [2:0] {
        SMB_IDLE, SMB_ADDR, SMB_ACK, SMB_RXB, SMB_TXB, SMB_MACK, SMB_SKIP
    } smb_state_e;
endpackage

// ---- core/smb_link.sv ----
// Bit-level slave engine on the link clock
`timescale 1ns/1ns
`default_nettype none
`include "smb_regs.svh"
module smb_link
    import smb_pkg::*;
(
    input  wire logic       link_clk,
    input  wire logic       link_rst,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_oe,
    input  wire logic [6:0] slave_addr,
    input  wire logic [7:0] state_byte,
    output logic            cmd_tgl,
    output logic [7:0]      cmd_reg,
    output logic [7:0]      cmd_data
);
    logic [1:0] scl_s_q, sda_s_q;
    logic       scl_q, sda_q;
    smb_state_e st_q, ret_q;
    logic [3:0] bit_q;
    logic [7:0] sh_q;
    logic [1:0] byte_q;
    logic       start, stop, rise, fall;

    // Two-stage synchronisers; the second stage and its delayed copy are looked at
    always_ff @(posedge link_clk) begin
        scl_s_q <= {scl_s_q[0], scl_i};
        sda_s_q <= {sda_s_q[0], sda_i};
        scl_q   <= scl_s_q[1];
        sda_q   <= sda_s_q[1];
    end

    assign start = scl_s_q[1] && scl_q && sda_q && !sda_s_q[1];
    assign stop  = scl_s_q[1] && scl_q && !sda_q && sda_s_q[1];
    assign rise  = scl_s_q[1] && !scl_q;
    assign fall  = !scl_s_q[1] && scl_q;

    // Byte-level protocol walker
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            st_q      <= SMB_IDLE;
            ret_q     <= SMB_IDLE;
            bit_q     <= 4'h0;
            sh_q      <= 8'h00;
            byte_q    <= 2'h0;
            sda_oe    <= 1'b0;
            cmd_tgl   <= 1'b0;
            cmd_reg   <= 8'h00;
            cmd_data  <= 8'h00;
        end else if (stop) begin
            st_q   <= SMB_IDLE;
            sda_oe <= 1'b0;
        end else if (start) begin
            st_q   <= SMB_ADDR;
            bit_q  <= 4'h0;
            sda_oe <= 1'b0;
        end else begin
            case (st_q)
                SMB_IDLE: ;
                SMB_ADDR, SMB_RXB: begin
                    if (rise) begin
                        sh_q  <= {sh_q[6:0], sda_q};
                        bit_q <= bit_q + 4'h1;
                    end else if (fall && bit_q == 4'h8) begin
                        bit_q <= 4'h0;
                        if (st_q == SMB_ADDR) begin
                            if (sh_q[7:1] == slave_addr) begin
                                byte_q <= 2'h0;
                                sda_oe <= 1'b1;
                                st_q   <= SMB_ACK;
                                ret_q  <= sh_q[0] ? SMB_TXB : SMB_RXB;
                                sh_q   <= sh_q[0] ? state_byte : 8'h00;
                            end else begin
                                st_q <= SMB_SKIP;
                            end
                        end else begin
                            sda_oe <= 1'b1;
                            st_q   <= SMB_ACK;
                            ret_q  <= SMB_RXB;
                            // Register byte doubles as the read-back select
                            if (byte_q == 2'h0) begin
                                cmd_reg <= sh_q;
                            end else if (byte_q == 2'h1) begin
                                cmd_data <= sh_q;
                                cmd_tgl  <= ~cmd_tgl;
                            end
                            if (byte_q != 2'h3) begin
                                byte_q <= byte_q + 2'h1;
                            end
                        end
                    end
                end
                SMB_ACK: begin
                    if (fall) begin
                        st_q   <= ret_q;
                        sda_oe <= (ret_q == SMB_TXB) && !sh_q[7];
                    end
                end
                SMB_TXB: begin
                    if (fall) begin
                        bit_q <= bit_q + 4'h1;
                        if (bit_q == 4'h7) begin
                            sda_oe <= 1'b0;
                            st_q   <= SMB_MACK;
                        end else begin
                            sda_oe <= !sh_q[6];
                            sh_q   <= {sh_q[6:0], 1'b0};
                        end
                    end
                end
                SMB_MACK: begin
                    // Master not-ack ends the read; later bytes ignored
                    if (rise) begin
                        st_q <= SMB_SKIP;
                    end
                end
                SMB_SKIP: ;
                default: st_q <= SMB_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- sim/smb_master.sv ----
// Behavioural two-wire bus master for the management slave
`timescale 1ns/1ns
`default_nettype none
module smb_master (
    input  wire logic link_clk,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_drv
);
    // Both lines rest high between frames; SCL does not run
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic tk(input int n);
        repeat (n) @(posedge link_clk);
        #1;
    endtask
    // Long phases leave room for the slave's synchroniser lag
    task automatic bt(input logic b, output logic r);
        sda_drv = b;
        tk(6);
        scl = 1'b1;
        tk(3);
        r = sda_line;
        tk(3);
        scl = 1'b0;
        tk(1);
    endtask
    task automatic by(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bt(d[i], r);
        bt(1'b1, r);
        ack = !r;
    endtask
    task automatic st;
        sda_drv = 1'b0;
        tk(4);
        scl = 1'b0;
        tk(2);
    endtask
    task automatic sp;
        sda_drv = 1'b0;
        tk(4);
        scl = 1'b1;
        tk(4);
        sda_drv = 1'b1;
        tk(6);
    endtask
    // Byte write: start, address, register, data, stop
    task automatic wr(input logic [6:0] a, input logic [7:0] rg, dt,
                      output logic ok);
        logic k0, k1, k2;
        st();
        by({a, 1'b0}, k0);
        by(rg, k1);
        by(dt, k2);
        sp();
        ok = k0 & k1 & k2;
    endtask
    // Byte read with repeated start and closing not-ack
    task automatic rd(input logic [7:0] rg, output logic [7:0] d,
                      output logic ok);
        logic k0, k1, k2, r;
        st();
        by(8'h88, k0);
        by(rg, k1);
        sda_drv = 1'b1;
        tk(4);
        scl = 1'b1;
        tk(4);
        st();
        by(8'h89, k2);
        for (int i = 7; i >= 0; i--) begin
            bt(1'b1, r);
            d[i] = r;
        end
        bt(1'b1, r);
        sp();
        ok = k0 & k1 & k2;
    endtask
endmodule
`default_nettype wire

// ---- sim/smb_slave_cmd_chk.sv ----
// Port assertions for the management slave command decoder
`timescale 1ns/1ns
`default_nettype none
module smb_slave_cmd_chk (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       resume_well_reset_n,
    input wire logic [2:0] power_state,
    input wire logic       wake_request,
    input wire logic       system_mgmt_interrupt,
    input wire logic       wake_event_status,
    input wire logic       power_button_override_status,
    input wire logic       reset_port_strobe,
    input wire logic [3:0] reset_port_value,
    input wire logic       messaging_enable,
    input wire logic       watchdog_reload,
    input wire logic       link_slave_mgmt_irq_status,
    input wire logic       link_slave_mgmt_irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Fully on state decode
    wire logic s0 = power_state == 3'h0;
    a_wake_asleep: assert property (wake_request |-> !s0)
        else $error("wake pulse while fully on");
    a_smi_awake: assert property (system_mgmt_interrupt |-> s0)
        else $error("interrupt while asleep");
    a_wake_status: assert property ((wake_request || system_mgmt_interrupt)
        |-> ##[0:2] wake_event_status)
        else $error("wake status not set");
    a_pbo_sticky: assert property (power_button_override_status
        |=> power_button_override_status)
        else $error("override status dropped");
    a_rst_code: assert property (reset_port_strobe |-> ##[0:1]
        reset_port_value inside {4'h6, 4'hE})
        else $error("bad reset port value");
    a_warm_in_s0: assert property (reset_port_strobe |-> ##[0:1]
        (reset_port_value == 4'hE || s0))
        else $error("warm reset outside fully on");
    a_msg_held: assert property (!messaging_enable && resume_well_reset_n
        && $past(resume_well_reset_n, 8) |=> !messaging_enable)
        else $error("messaging re-enabled without reset");
    a_wd_pulse: assert property (watchdog_reload |=> !watchdog_reload)
        else $error("reload pulse too long");
    a_link_s0: assert property ($rose(link_slave_mgmt_irq_status)
        |-> s0)
        else $error("link status set while asleep");
    a_irq_follow: assert property (link_slave_mgmt_irq_status && s0
        |=> link_slave_mgmt_irq)
        else $error("pending link interrupt not raised");
    a_irq_gated: assert property (!(link_slave_mgmt_irq_status && s0)
        |=> !link_slave_mgmt_irq)
        else $error("link interrupt without cause");
    c_wake: cover property (wake_request);
    c_smi: cover property (system_mgmt_interrupt);
    c_irq: cover property (link_slave_mgmt_irq);
endmodule
bind smb_slave_cmd smb_slave_cmd_chk u_chk (
    .clk                          (clk),
    .sys_rst                      (sys_rst),
    .resume_well_reset_n          (resume_well_reset_n),
    .power_state                  (power_state),
    .wake_request                 (wake_request),
    .system_mgmt_interrupt        (system_mgmt_interrupt),
    .wake_event_status            (wake_event_status),
    .power_button_override_status (power_button_override_status),
    .reset_port_strobe            (reset_port_strobe),
    .reset_port_value             (reset_port_value),
    .messaging_enable             (messaging_enable),
    .watchdog_reload              (watchdog_reload),
    .link_slave_mgmt_irq_status   (link_slave_mgmt_irq_status),
    .link_slave_mgmt_irq          (link_slave_mgmt_irq)
);
`default_nettype wire

// ---- sim/smb_slave_cmd_tb.sv ----
// Testbench for the management slave command decoder
`timescale 1ns/1ns
`default_nettype none
module smb_slave_cmd_tb;
    logic       clk = 1'b0, link_clk = 1'b0, sys_rst = 1'b1;
    logic       resume_well_reset_n = 1'b1, mgmt_power_on = 1'b1;
    logic       graceful_sleep = 1'b0, wake_status_clr = 1'b0;
    logic       link_slave_status_clr = 1'b0;
    logic [2:0] power_state = 3'h0;
    logic [6:0] receive_slave_address = 7'h44;
    logic       scl_i, sda_drv, sda_oe, wake_request, system_mgmt_interrupt;
    logic       wake_event_status, power_button_override_status, msg;
    logic       reset_port_strobe, watchdog_reload, lst, lirq;
    logic [3:0] reset_port_value;
    wire logic  sda_i = sda_drv & ~sda_oe;
    int         mismatches = 0, num_checks = 0;
    int         c[4] = '{default: 0};
    smb_master u_master (.link_clk(link_clk), .sda_line(sda_i),
                         .scl(scl_i), .sda_drv(sda_drv));
    smb_slave_cmd uut (
        .clk                          (clk),
        .sys_rst                      (sys_rst),
        .link_clk                     (link_clk),
        .link_rst                     (sys_rst),
        .resume_well_reset_n          (resume_well_reset_n),
        .scl_i                        (scl_i),
        .sda_i                        (sda_i),
        .sda_o                        (),
        .sda_oe                       (sda_oe),
        .receive_slave_address        (receive_slave_address),
        .power_state                  (power_state),
        .mgmt_power_on                (mgmt_power_on),
        .graceful_sleep               (graceful_sleep),
        .wake_status_clr              (wake_status_clr),
        .link_slave_status_clr        (link_slave_status_clr),
        .wake_request                 (wake_request),
        .system_mgmt_interrupt        (system_mgmt_interrupt),
        .wake_event_status            (wake_event_status),
        .power_button_override_status (power_button_override_status),
        .reset_port_strobe            (reset_port_strobe),
        .reset_port_value             (reset_port_value),
        .messaging_enable             (msg),
        .watchdog_reload              (watchdog_reload),
        .link_slave_mgmt_irq_status   (lst),
        .link_slave_mgmt_irq          (lirq)
    );
    // Clocks unrelated in phase
    always #5 clk = ~clk;
    initial begin
        #3;
        forever #15 link_clk = ~link_clk;
    end
    // Tally of single-cycle pulses
    always @(posedge clk) begin
        if (wake_request) c[0] <= c[0] + 1;
        if (system_mgmt_interrupt) c[1] <= c[1] + 1;
        if (reset_port_strobe) c[2] <= c[2] + 1;
        if (watchdog_reload) c[3] <= c[3] + 1;
    end
    task automatic chk(input logic [7:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    // One-cycle clear pulse: wake status, or link status when lnk is set
    task automatic clr(input logic lnk);
        @(negedge clk);
        if (lnk) link_slave_status_clr = 1'b1;
        else wake_status_clr = 1'b1;
        @(negedge clk);
        link_slave_status_clr = 1'b0;
        wake_status_clr = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    task automatic cfg(input logic [2:0] p, input logic m, g);
        @(negedge clk);
        power_state = p;
        mgmt_power_on = m;
        graceful_sleep = g;
        repeat (3) @(negedge clk);
    endtask
    // Pulse deltas: bit 0 wake, 1 interrupt, 2 reset, 3 reload
    task automatic cmd(input logic [7:0] code, input logic [3:0] dl);
        int b[4];
        logic ok;
        b = c;
        u_master.wr(7'h44, 8'h00, code, ok);
        repeat (40) @(negedge clk);
        chk({7'h0, ok}, 8'h01);
        for (int i = 0; i < 4; i++) chk(8'(c[i] - b[i]), {7'h0, dl[i]});
    endtask
    task automatic sc_wake;
        cfg(3'h3, 1'b1, 1'b0);
        cmd(8'h01, 4'b0001);
        chk(wake_event_status, 8'h01);
        clr(1'b0);
        cfg(3'h0, 1'b1, 1'b0);
        chk(wake_event_status, 8'h00);
        cmd(8'h01, 4'b0010);
        chk(wake_event_status, 8'h01);
    endtask
    task automatic sc_reset;
        cmd(8'h03, 4'b0100);
        chk(reset_port_value, 8'h06);
        cfg(3'h4, 1'b1, 1'b0);
        cmd(8'h03, 4'b0000);
        chk(reset_port_value, 8'h06);
        cmd(8'h04, 4'b0100);
        chk(reset_port_value, 8'h0E);
        cfg(3'h5, 1'b0, 1'b0);
        cmd(8'h04, 4'b0000);
        cfg(3'h5, 1'b0, 1'b1);
        cmd(8'h04, 4'b0100);
    endtask
    task automatic sc_link;
        cfg(3'h3, 1'b1, 1'b0);
        cmd(8'h08, 4'b0000);
        chk(lst, 8'h00);
        cfg(3'h0, 1'b1, 1'b0);
        cmd(8'h08, 4'b0000);
        chk({lst, lirq}, 8'h03);
        cfg(3'h3, 1'b1, 1'b0);
        chk({lst, lirq}, 8'h02);
        cfg(3'h0, 1'b1, 1'b0);
        chk({lst, lirq}, 8'h03);
        clr(1'b1);
        chk({lst, lirq}, 8'h00);
    endtask
    task automatic sc_misc;
        logic [7:0] rc[4] = '{8'h00, 8'h07, 8'h09, 8'hFF};
        cmd(8'h02, 4'b0000);
        chk(power_button_override_status, 8'h01);
        cmd(8'h06, 4'b1000);
        clr(1'b0);
        foreach (rc[i]) cmd(rc[i], 4'b0000);
        chk({wake_event_status, lst, msg}, 8'h01);
        cmd(8'h05, 4'b0000);
        chk(msg, 8'h00);
        resume_well_reset_n = 1'b0;
        repeat (10) @(negedge clk);
        resume_well_reset_n = 1'b1;
        repeat (20) @(negedge clk);
        chk(msg, 8'h01);
    endtask
    task automatic sc_read;
        logic [7:0] d;
        logic [2:0] ps[4] = '{3'h0, 3'h3, 3'h4, 3'h5};
        logic ok;
        u_master.rd(8'h00, d, ok);
        chk(d, 8'h00);
        chk({7'h0, ok}, 8'h01);
        foreach (ps[i]) begin
            cfg(ps[i], 1'b1, 1'b0);
            u_master.rd(8'h01, d, ok);
            chk(d, {5'h0, ps[i]});
        end
        u_master.wr(7'h45, 8'h00, 8'h06, ok);
        repeat (40) @(negedge clk);
        chk({c[3][6:0], ok}, 8'h02);
    endtask
    task automatic complete_run;
        if (mismatches == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Main sequence; wait after reset before the first frame
    initial begin
        repeat (8) @(negedge clk);
        sys_rst = 1'b0;
        repeat (20) @(negedge clk);
        sc_wake();
        sc_reset();
        sc_link();
        sc_misc();
        sc_read();
        complete_run();
    end
    // Hang guard
    initial begin
        repeat (100000) @(posedge clk);
        mismatches++;
        complete_run();
    end
endmodule
`default_nettype wire
